// ### include/nsc_params.svh
// Behaviour
// - Only 15 address bits reach memory
// - Four accumulators; third/fourth index, fourth links
// - Four-bit ALU, four nibble steps per word
// - Carry plus result rotates left or right
// - Result waits in scratch until the next computing state
// - Instruction and bus registers load separately
// - PC increments, reloads on jumps, skips one word
// - 72 operations, 24-bit control, 19 inputs
// - Microcycles with 16 states, four nibble phases
// - Cycle strobe low once per microcycle
// - Service request taken at instruction end, enabled
// - Granted channel device drives memory lines itself
// - Priority: reset, channel, service, halt
// - Read and write strobes active low
// - Memory lines released during channel transfer
// - Strobe withheld while memory wait low, on memory microcycles only
// - Latch/write cycles wait for wait low
// - Read waits for wait low then high
// - Jump loads PC; call saves PC+1 first
// - Increment/decrement memory, skip on zero
// - Load copies word to selected accumulator
// - Store writes accumulator, leaves it unchanged
// - Pointer top bit chains indirection levels
`ifndef NSC_PARAMS_SVH
`define NSC_PARAMS_SVH

`define NSC_NIBBLES      4
`define NSC_PH_SETTLE    3'h0
`define NSC_PH_FIRST     3'h1
`define NSC_PH_END       3'h5
`define NSC_PC_RESET     15'h0000
`define NSC_INT_SAVE     15'h0000
`define NSC_INT_PTR      15'h0001
`define NSC_IR_INT_JMP   16'h0400
`define NSC_SYNC_RST     22'h00_0021
`define NSC_ONE          16'h0001
`define NSC_MINUS_ONE    16'hFFFF
`define NSC_DEV_CPU      6'h3F
`define NSC_IE_SET       2'h1
`define NSC_IE_CLR       2'h2
`define NSC_F_CLASS      15
`define NSC_F_GRP        14:13
`define NSC_F_ACS        14:13
`define NSC_F_ACD        12:11
`define NSC_F_MOP        12:11
`define NSC_F_IND        10
`define NSC_F_MODE       9:8
`define NSC_F_DISP       7:0
`define NSC_F_FN         10:8
`define NSC_F_SHIFT      7:6
`define NSC_F_NOLOAD     3
`define NSC_F_IOCTL      7:6
`define NSC_F_DEV        5:0
`define NSC_F_PTRIND     15
`define NSC_F_ADDR       14:0

`endif

// ### include/nsc_pkg.sv
package nsc_pkg;

	typedef enum logic [15:0] {
		NSC_S_RESET   = 16'h0001,
		NSC_S_FETCH_L = 16'h0002,
		NSC_S_FETCH_R = 16'h0004,
		NSC_S_DECODE  = 16'h0008,
		NSC_S_IND_L   = 16'h0010,
		NSC_S_IND_R   = 16'h0020,
		NSC_S_OPER_L  = 16'h0040,
		NSC_S_OPER_R  = 16'h0080,
		NSC_S_MODIFY  = 16'h0100,
		NSC_S_STORE_L = 16'h0200,
		NSC_S_STORE_W = 16'h0400,
		NSC_S_WRBACK  = 16'h0800,
		NSC_S_INT_L   = 16'h1000,
		NSC_S_INT_W   = 16'h2000,
		NSC_S_DMA     = 16'h4000,
		NSC_S_HALT    = 16'h8000
	} nsc_state_t;

	typedef enum logic [1:0] {
		NSC_MEM_NONE  = 2'h0,
		NSC_MEM_LATCH = 2'h1,
		NSC_MEM_READ  = 2'h2,
		NSC_MEM_WRITE = 2'h3
	} nsc_mem_t;

endpackage

// ### design/nsc_nib_alu.sv
`timescale 1ns/1ns
module nsc_nib_alu (
	// Operands
	input  wire logic [3:0] a,
	input  wire logic [3:0] b,
	input  wire logic       cin,
	input  wire logic       fn_and,
	// Result
	output logic      [3:0] y,
	output logic            cout
);
	wire logic [4:0] sum_w;

	assign sum_w = {1'b0, a} + {1'b0, b} + {4'h0, cin};
	assign y     = fn_and ? (a & b) : sum_w[3:0];
	assign cout  = fn_and ? 1'b0 : sum_w[4];
endmodule

// ### design/nsc_cpu.sv
`timescale 1ns/1ns
`include "nsc_params.svh"
module nsc_cpu #(
	parameter int NIBBLES = `NSC_NIBBLES
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// Control pins
	input  wire logic        master_reset_n,
	input  wire logic        direct_memory_request,
	input  wire logic        service_request_line,
	input  wire logic        console_halt,
	input  wire logic        console_continue,
	output logic             dma_grant,
	output logic             cycle_strobe_n,
	// Memory handshake
	input  wire logic        memory_wait_n,
	input  wire logic        read_strobe_n_i,
	output logic             read_strobe_n_o,
	output logic             read_strobe_n_oe,
	input  wire logic        write_strobe_n_i,
	output logic             write_strobe_n_o,
	output logic             write_strobe_n_oe,
	input  wire logic        address_load_n_i,
	output logic             address_load_n_o,
	output logic             address_load_n_oe,
	// Information bus
	input  wire logic [15:0] info_bus_i,
	output logic      [15:0] info_bus_o,
	output logic             info_bus_oe
);
	if (NIBBLES != `NSC_NIBBLES) begin : g_chk
		$error("nsc_cpu: the datapath serves four nibbles only");
	end

	function automatic logic [3:0] nib_of(input logic [15:0] w, input logic [1:0] i);
		return w[{i, 2'b00} +: 4];
	endfunction

	function automatic logic [16:0] rot17(input logic [15:0] r, input logic c,
		input logic [1:0] sh);
		case (sh)
			2'h1: return {r, c};
			2'h2: return {r[0], c, r[15:1]};
			2'h3: return {c, r[7:0], r[15:8]};
			default: return {c, r};
		endcase
	endfunction

	// Pin synchronisers
	logic [21:0] s1_q;
	logic [21:0] s2_q;
	wire logic [15:0] bus_s;
	wire logic        wait_s;
	wire logic        dma_s;
	wire logic        srq_s;
	wire logic        halt_s;
	wire logic        cont_s;
	wire logic        mr_s;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s1_q <= `NSC_SYNC_RST;
			s2_q <= `NSC_SYNC_RST;
		end else begin
			s1_q <= {info_bus_i, memory_wait_n, direct_memory_request,
				service_request_line, console_halt, console_continue, master_reset_n};
			s2_q <= s1_q;
		end
	end
	assign {bus_s, wait_s, dma_s, srq_s, halt_s, cont_s, mr_s} = s2_q;

	// Architectural state
	nsc_pkg::nsc_state_t st_q;
	logic [2:0]  ph_q;
	logic        half_q;
	logic        seen_q;
	logic [14:0] pc_q;
	logic [15:0] ir_q;
	logic [15:0] bus_q;
	logic [15:0] scr_q;
	logic [15:0] acc_q [4];
	logic [14:0] ea_q;
	logic        cy_q;
	logic        carry_q;
	logic        ncy_q;
	logic        ie_q;
	logic        grant_q;
	logic        strobe_n_q;
	logic        ro_q;
	logic        wo_q;
	logic        lo_q;
	logic        bus_oe_q;
	logic [15:0] bus_o_q;

	// Instruction decode
	wire logic        is_alu;
	wire logic        is_io;
	wire logic [1:0]  grp;
	wire logic [1:0]  mop;
	wire logic [2:0]  fn;
	wire logic [15:0] disp_w;
	wire logic [15:0] base_w;
	wire logic [15:0] src_w;
	wire logic [15:0] dst_w;

	assign is_alu = ir_q[`NSC_F_CLASS];
	assign grp    = ir_q[`NSC_F_GRP];
	assign mop    = ir_q[`NSC_F_MOP];
	assign fn     = ir_q[`NSC_F_FN];
	assign is_io  = !is_alu && (grp == 2'h3);
	assign src_w  = acc_q[ir_q[`NSC_F_ACS]];
	assign dst_w  = acc_q[ir_q[`NSC_F_ACD]];
	assign disp_w = (ir_q[`NSC_F_MODE] == 2'h0) ? {8'h00, ir_q[`NSC_F_DISP]} :
		{{8{ir_q[7]}}, ir_q[`NSC_F_DISP]};
	assign base_w = (ir_q[`NSC_F_MODE] == 2'h1) ? {1'b0, pc_q} :
		(ir_q[`NSC_F_MODE] == 2'h2) ? acc_q[2] :
		(ir_q[`NSC_F_MODE] == 2'h3) ? acc_q[3] : 16'h0000;

	// Memory cycle kind of the present state
	wire nsc_pkg::nsc_mem_t mk_w;
	assign mk_w = (st_q inside {nsc_pkg::NSC_S_FETCH_L, nsc_pkg::NSC_S_IND_L,
		nsc_pkg::NSC_S_OPER_L, nsc_pkg::NSC_S_STORE_L, nsc_pkg::NSC_S_INT_L}) ?
		nsc_pkg::NSC_MEM_LATCH :
		(st_q inside {nsc_pkg::NSC_S_FETCH_R, nsc_pkg::NSC_S_IND_R,
		nsc_pkg::NSC_S_OPER_R}) ? nsc_pkg::NSC_MEM_READ :
		(st_q inside {nsc_pkg::NSC_S_STORE_W, nsc_pkg::NSC_S_INT_W}) ?
		nsc_pkg::NSC_MEM_WRITE : nsc_pkg::NSC_MEM_NONE;

	// Microcycle engine
	wire logic start_ok;
	wire logic hs_done;
	wire logic uc_done;
	wire logic adv;
	wire logic strobe_go;
	wire logic nib_step;
	wire logic [1:0] nib_w;

	assign start_ok  = (mk_w == nsc_pkg::NSC_MEM_NONE) || wait_s;
	assign hs_done   = (mk_w == nsc_pkg::NSC_MEM_NONE) ? 1'b1 :
		(mk_w == nsc_pkg::NSC_MEM_READ) ? (seen_q && wait_s) : seen_q;
	assign uc_done   = (ph_q == `NSC_PH_END) && hs_done;
	assign adv       = half_q && (ph_q != `NSC_PH_END) &&
		((ph_q != `NSC_PH_SETTLE) || start_ok);
	assign strobe_go = adv && (ph_q == `NSC_PH_SETTLE);
	assign nib_step  = adv && (ph_q != `NSC_PH_SETTLE);
	assign nib_w     = 2'(ph_q - `NSC_PH_FIRST);

	always_ff @(posedge mclk) begin
		if (!rstn || !mr_s) begin
			half_q <= 1'b0;
			ph_q   <= `NSC_PH_SETTLE;
			seen_q <= 1'b0;
		end else begin
			half_q <= !half_q;
			if (uc_done) begin
				ph_q   <= `NSC_PH_SETTLE;
				seen_q <= 1'b0;
			end else begin
				if (adv)
					ph_q <= ph_q + 3'h1;
				if (ph_q != `NSC_PH_SETTLE && !wait_s)
					seen_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn)
			strobe_n_q <= 1'b1;
		else
			strobe_n_q <= !(strobe_go && mr_s);
	end

	// Nibble-serial arithmetic
	wire logic [15:0] a_w;
	wire logic [15:0] b_w;
	wire logic        cin0;
	wire logic        and_w;
	wire logic [3:0]  y_w;
	wire logic        co_w;
	wire logic        dec_alu;
	wire logic        dec_mri;
	wire logic        in_mod;
	wire logic        alu_live;

	assign dec_alu = (st_q == nsc_pkg::NSC_S_DECODE) && is_alu;
	assign dec_mri = (st_q == nsc_pkg::NSC_S_DECODE) && !is_alu;
	assign in_mod  = (st_q == nsc_pkg::NSC_S_MODIFY);
	// Scratch only shifts while computing, so it holds its result until the next DECODE or MODIFY state
	assign alu_live = dec_alu || dec_mri || in_mod;
	assign a_w  = dec_alu ? (fn[1] ? src_w : ~src_w) :
		dec_mri ? base_w : in_mod ? bus_q : 16'h0000;
	assign b_w  = dec_alu ? (fn[2] ? dst_w : 16'h0000) :
		dec_mri ? disp_w :
		in_mod ? ((mop == 2'h2) ? `NSC_ONE : `NSC_MINUS_ONE) : 16'h0000;
	assign cin0  = dec_alu && fn[0] && (fn != 3'h7);
	assign and_w = dec_alu && (fn == 3'h7);

	nsc_nib_alu u_alu (
		.a      (nib_of(a_w, nib_w)),
		.b      (nib_of(b_w, nib_w)),
		.cin    ((ph_q == `NSC_PH_FIRST) ? cin0 : cy_q),
		.fn_and (and_w),
		.y      (y_w),
		.cout   (co_w)
	);

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			scr_q <= 16'h0000;
			cy_q  <= 1'b0;
		end else if (nib_step && alu_live) begin
			scr_q <= {y_w, scr_q[15:4]};
			cy_q  <= co_w;
		end
	end

	// Bus drive, open-drain strobes
	wire logic [14:0] lat_addr;
	wire logic [15:0] wr_data;
	assign lat_addr = (st_q == nsc_pkg::NSC_S_FETCH_L) ? pc_q :
		(st_q == nsc_pkg::NSC_S_INT_L) ? `NSC_INT_SAVE : ea_q;
	assign wr_data  = (st_q == nsc_pkg::NSC_S_INT_W) ? {1'b0, pc_q} :
		(grp == 2'h2) ? dst_w : scr_q;

	always_ff @(posedge mclk) begin
		if (!rstn || !mr_s || uc_done) begin
			ro_q     <= 1'b0;
			wo_q     <= 1'b0;
			lo_q     <= 1'b0;
			bus_oe_q <= 1'b0;
			bus_o_q  <= 16'h0000;
		end else if (strobe_go) begin
			ro_q     <= (mk_w == nsc_pkg::NSC_MEM_READ);
			wo_q     <= (mk_w == nsc_pkg::NSC_MEM_WRITE);
			lo_q     <= (mk_w == nsc_pkg::NSC_MEM_LATCH);
			bus_oe_q <= (mk_w == nsc_pkg::NSC_MEM_LATCH) || (mk_w == nsc_pkg::NSC_MEM_WRITE);
			bus_o_q  <= (mk_w == nsc_pkg::NSC_MEM_LATCH) ? {1'b0, lat_addr} : wr_data;
		end
	end

	// Sequencer
	nsc_pkg::nsc_state_t arb_st;
	nsc_pkg::nsc_state_t ea_st;
	wire logic [14:0] ea_new;
	wire logic [16:0] rot_w;
	wire logic        ptr_more;

	assign arb_st = dma_s ? nsc_pkg::NSC_S_DMA :
		(srq_s && ie_q) ? nsc_pkg::NSC_S_INT_L :
		halt_s ? nsc_pkg::NSC_S_HALT : nsc_pkg::NSC_S_FETCH_L;
	assign ea_new   = (st_q == nsc_pkg::NSC_S_IND_R) ? bus_s[`NSC_F_ADDR] : scr_q[`NSC_F_ADDR];
	assign ptr_more = (st_q == nsc_pkg::NSC_S_IND_R) ? bus_s[`NSC_F_PTRIND] : ir_q[`NSC_F_IND];
	assign ea_st    = (grp == 2'h1 || (grp == 2'h0 && mop[1])) ? nsc_pkg::NSC_S_OPER_L :
		(grp == 2'h2) ? nsc_pkg::NSC_S_STORE_L : arb_st;
	assign rot_w    = rot17(scr_q, ncy_q, ir_q[`NSC_F_SHIFT]);

	always_ff @(posedge mclk) begin
		if (!rstn || !mr_s) begin
			st_q    <= nsc_pkg::NSC_S_RESET;
			pc_q    <= `NSC_PC_RESET;
			ir_q    <= 16'h0000;
			bus_q   <= 16'h0000;
			ea_q    <= 15'h0000;
			carry_q <= 1'b0;
			ncy_q   <= 1'b0;
			ie_q    <= 1'b0;
			grant_q <= 1'b0;
			acc_q   <= '{default: 16'h0000};
		end else if (uc_done) begin
			unique case (st_q)
				nsc_pkg::NSC_S_RESET:   st_q <= nsc_pkg::NSC_S_FETCH_L;
				nsc_pkg::NSC_S_FETCH_L: st_q <= nsc_pkg::NSC_S_FETCH_R;
				nsc_pkg::NSC_S_FETCH_R: begin
					ir_q <= bus_s;
					pc_q <= pc_q + 15'h0001;
					st_q <= nsc_pkg::NSC_S_DECODE;
				end
				nsc_pkg::NSC_S_DECODE: begin
					if (is_alu) begin
						ncy_q <= carry_q ^ cy_q;
						st_q  <= nsc_pkg::NSC_S_WRBACK;
					end else if (is_io) begin
						if (ir_q[`NSC_F_DEV] == `NSC_DEV_CPU &&
							ir_q[`NSC_F_IOCTL] == `NSC_IE_SET)
							ie_q <= 1'b1;
						if (ir_q[`NSC_F_DEV] == `NSC_DEV_CPU &&
							ir_q[`NSC_F_IOCTL] == `NSC_IE_CLR)
							ie_q <= 1'b0;
						st_q <= arb_st;
					end else begin
						ea_q <= ea_new;
						if (ptr_more)
							st_q <= nsc_pkg::NSC_S_IND_L;
						else if (grp == 2'h0 && !mop[1]) begin
							if (mop[0])
								acc_q[3] <= {1'b0, pc_q};
							pc_q <= ea_new;
							st_q <= arb_st;
						end else
							st_q <= ea_st;
					end
				end
				nsc_pkg::NSC_S_IND_L:   st_q <= nsc_pkg::NSC_S_IND_R;
				nsc_pkg::NSC_S_IND_R: begin
					ea_q <= ea_new;
					if (ptr_more)
						st_q <= nsc_pkg::NSC_S_IND_L;
					else if (grp == 2'h0 && !mop[1]) begin
						if (mop[0])
							acc_q[3] <= {1'b0, pc_q};
						pc_q <= ea_new;
						st_q <= arb_st;
					end else
						st_q <= ea_st;
				end
				nsc_pkg::NSC_S_OPER_L:  st_q <= nsc_pkg::NSC_S_OPER_R;
				nsc_pkg::NSC_S_OPER_R: begin
					bus_q <= bus_s;
					if (grp == 2'h1) begin
						acc_q[ir_q[`NSC_F_ACD]] <= bus_s;
						st_q <= arb_st;
					end else
						st_q <= nsc_pkg::NSC_S_MODIFY;
				end
				nsc_pkg::NSC_S_MODIFY:  st_q <= nsc_pkg::NSC_S_STORE_L;
				nsc_pkg::NSC_S_STORE_L: st_q <= nsc_pkg::NSC_S_STORE_W;
				nsc_pkg::NSC_S_STORE_W: begin
					if (grp == 2'h0 && scr_q == 16'h0000)
						pc_q <= pc_q + 15'h0001;
					st_q <= arb_st;
				end
				nsc_pkg::NSC_S_WRBACK: begin
					if (!ir_q[`NSC_F_NOLOAD]) begin
						acc_q[ir_q[`NSC_F_ACD]] <= rot_w[15:0];
						carry_q <= rot_w[16];
					end
					st_q <= arb_st;
				end
				nsc_pkg::NSC_S_INT_L: begin
					ie_q <= 1'b0;
					st_q <= nsc_pkg::NSC_S_INT_W;
				end
				nsc_pkg::NSC_S_INT_W: begin
					ea_q <= `NSC_INT_PTR;
					ir_q <= `NSC_IR_INT_JMP;
					st_q <= nsc_pkg::NSC_S_IND_L;
				end
				nsc_pkg::NSC_S_DMA: begin
					grant_q <= dma_s;
					if (!dma_s)
						st_q <= arb_st;
				end
				nsc_pkg::NSC_S_HALT: begin
					if (dma_s || cont_s)
						st_q <= dma_s ? nsc_pkg::NSC_S_DMA : nsc_pkg::NSC_S_FETCH_L;
				end
				default: st_q <= nsc_pkg::NSC_S_RESET;
			endcase
		end
	end

	// Output pins
	assign dma_grant         = grant_q;
	assign cycle_strobe_n    = strobe_n_q;
	assign read_strobe_n_oe  = ro_q;
	assign write_strobe_n_oe = wo_q;
	assign address_load_n_oe = lo_q;
	assign read_strobe_n_o   = !ro_q;
	assign write_strobe_n_o  = !wo_q;
	assign address_load_n_o  = !lo_q;
	assign info_bus_o        = bus_o_q;
	assign info_bus_oe       = bus_oe_q;

	// Checks
	a_strobe_phase: assert property (@(posedge mclk) disable iff (!rstn)
		!cycle_strobe_n |-> ph_q == `NSC_PH_FIRST ##1 cycle_strobe_n)
		else $error("cycle strobe outside microcycle start");
	a_wait_holds: assert property (@(posedge mclk) disable iff (!rstn)
		(ph_q == `NSC_PH_SETTLE && mk_w != nsc_pkg::NSC_MEM_NONE && !wait_s)
		|=> cycle_strobe_n)
		else $error("strobe issued while memory busy");
	a_latch_wait: assert property (@(posedge mclk) disable iff (!rstn || !mr_s)
		(uc_done && (mk_w == nsc_pkg::NSC_MEM_LATCH || mk_w == nsc_pkg::NSC_MEM_WRITE))
		|-> seen_q)
		else $error("latch or write ended before wait low");
	a_read_wait: assert property (@(posedge mclk) disable iff (!rstn || !mr_s)
		(uc_done && mk_w == nsc_pkg::NSC_MEM_READ) |-> (seen_q && wait_s))
		else $error("read ended before wait cycle");
	a_dma_release: assert property (@(posedge mclk) disable iff (!rstn)
		(st_q == nsc_pkg::NSC_S_DMA) |-> !(ro_q || wo_q || lo_q || bus_oe_q))
		else $error("memory lines driven during channel transfer");
	a_mreset_abort: assert property (@(posedge mclk) disable iff (!rstn)
		!mr_s |=> (st_q == nsc_pkg::NSC_S_RESET && !ie_q && !read_strobe_n_oe))
		else $error("master reset not honoured");
	a_int_gated: assert property (@(posedge mclk) disable iff (!rstn || !mr_s)
		(st_q != nsc_pkg::NSC_S_INT_L ##1 st_q == nsc_pkg::NSC_S_INT_L) |-> $past(ie_q))
		else $error("interrupt taken while disabled");
	a_dma_first: assert property (@(posedge mclk) disable iff (!rstn || !mr_s)
		(uc_done && st_q == nsc_pkg::NSC_S_STORE_W && dma_s)
		|=> st_q == nsc_pkg::NSC_S_DMA)
		else $error("channel request lost priority");
	a_isz_skip: assert property (@(posedge mclk) disable iff (!rstn || !mr_s)
		(uc_done && st_q == nsc_pkg::NSC_S_STORE_W && grp == 2'h0 && scr_q == 16'h0000)
		|=> pc_q == $past(pc_q) + 15'h0001)
		else $error("zero result did not skip");
	a_addr_15: assert property (@(posedge mclk) disable iff (!rstn)
		address_load_n_oe |-> !info_bus_o[15])
		else $error("address wider than 15 bits");
endmodule

// ### sim/nsc_mem_model.sv
`timescale 1ns/1ns
module nsc_mem_model (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// Processor side
	input  wire logic        cycle_strobe_n,
	input  wire logic        rd_oe,
	input  wire logic        wr_oe,
	input  wire logic        al_oe,
	input  wire logic [15:0] bus_o,
	output logic      [15:0] bus_i,
	output logic             memory_wait_n,
	// Test controls
	input  wire logic        slow,
	input  wire logic        hold
);
	logic [15:0] ram [0:32767];
	logic [14:0] addr_q;
	logic [15:0] rdat_q;
	logic [3:0]  cnt_q;
	int          wr_top = 0;

	// Busy while an access runs or the bench forces a stall
	assign memory_wait_n = !(hold || cnt_q != 4'h0);
	// A released bus shows the inverse of the last word
	assign bus_i = rd_oe ? rdat_q : ~rdat_q;

	always @(posedge mclk) begin
		if (!rstn) begin
			cnt_q <= 4'h0;
		end else if (!cycle_strobe_n && (al_oe || wr_oe || rd_oe)) begin
			cnt_q <= slow ? 4'hC : 4'h2;
			if (al_oe)
				addr_q <= bus_o[14:0];
			if (wr_oe) begin
				ram[addr_q] <= bus_o;
				if (addr_q == 15'h007F)
					wr_top <= wr_top + 1;
			end
			if (rd_oe)
				rdat_q <= ram[addr_q];
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule

// ### sim/nsc_cpu_test.sv
`timescale 1ns/1ns
module nsc_cpu_test;
	logic        mclk, rstn, mr_n, dmr, srl, hold, slow, low_q;
	logic        grant, strobe_n, wait_n, rd_oe, wr_oe, al_oe, bus_oe;
	logic        rd_o, wr_o, al_o, halt, cont;
	logic [15:0] bus_i, bus_o;
	int          mismatches = 0;
	int          tests_run = 0;
	int          strobes = 0;

	nsc_cpu uut (
		.mclk(mclk), .rstn(rstn), .master_reset_n(mr_n),
		.direct_memory_request(dmr), .service_request_line(srl),
		.console_halt(halt), .console_continue(cont),
		.dma_grant(grant), .cycle_strobe_n(strobe_n), .memory_wait_n(wait_n),
		.read_strobe_n_i(!rd_oe), .read_strobe_n_o(rd_o), .read_strobe_n_oe(rd_oe),
		.write_strobe_n_i(!wr_oe), .write_strobe_n_o(wr_o), .write_strobe_n_oe(wr_oe),
		.address_load_n_i(!al_oe), .address_load_n_o(al_o), .address_load_n_oe(al_oe),
		.info_bus_i(bus_i), .info_bus_o(bus_o), .info_bus_oe(bus_oe)
	);

	nsc_mem_model mem (
		.mclk(mclk), .rstn(rstn), .cycle_strobe_n(strobe_n), .rd_oe(rd_oe),
		.wr_oe(wr_oe), .al_oe(al_oe), .bus_o(bus_o), .bus_i(bus_i),
		.memory_wait_n(wait_n), .slow(slow), .hold(hold)
	);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Strobe is a single-cycle pulse
	always @(posedge mclk) begin
		low_q <= !strobe_n;
		if (!strobe_n)
			strobes++;
		if (rstn && !strobe_n && low_q) begin
			mismatches++;
			$display("[ERR] %0t strobe held low two cycles", $time);
		end
		if ((rd_oe && rd_o !== 1'b0) || (wr_oe && wr_o !== 1'b0) ||
			(al_oe && al_o !== 1'b0)) begin
			mismatches++;
			$display("[ERR] %0t driven memory line not low", $time);
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#5;
	endtask

	task automatic prog(input logic [15:0] w [$]);
		for (int i = 0; i < 256; i++)
			mem.ram[i] = 16'h0000;
		foreach (w[i])
			mem.ram[i] = w[i];
	endtask

	task automatic restart();
		rstn = 1'b0;
		tick(3);
		rstn = 1'b1;
	endtask

	// Waits for the program's closing store, then checks it
	task automatic finish(input int base, input logic [15:0] exp);
		int n;
		for (n = 0; n < 6000 && mem.wr_top == base; n++)
			tick(1);
		chk(mem.ram[15'h007F], exp);
	endtask

	task automatic t_load();
		int base, s0;
		prog({16'h3010, 16'h5011, 16'h507F, 16'h0003});
		mem.ram[16] = 16'hA5C3;
		base = mem.wr_top;
		hold = 1'b1;
		restart();
		tick(60);
		s0 = strobes;
		tick(200);
		chk(16'(strobes - s0), 16'h0000);
		hold = 1'b0;
		finish(base, 16'hA5C3);
		chk(mem.ram[17], 16'hA5C3);
	endtask

	task automatic t_jump();
		int base, s0, bad, n;
		prog({16'h0005, 16'h587F, 16'h0000, 16'h0000, 16'h0000,
			16'h0808, 16'h0000, 16'h0000, 16'h587F, 16'h0009});
		base = mem.wr_top;
		slow = 1'b1;
		restart();
		tick(100);
		dmr = 1'b1;
		for (n = 0; n < 400 && grant !== 1'b1; n++)
			tick(1);
		chk(grant, 1'b1);
		s0 = strobes;
		bad = 0;
		for (int i = 0; i < 100; i++) begin
			tick(1);
			if (rd_oe | wr_oe | al_oe | bus_oe)
				bad++;
		end
		chk(16'(bad), 16'h0000);
		chk(strobes > s0, 1'b1);
		dmr = 1'b0;
		finish(base, 16'h0006);
		slow = 1'b0;
	endtask

	task automatic t_skip();
		int base;
		prog({16'h1010, 16'h0001, 16'h1811, 16'h2012, 16'h407F, 16'h0005});
		mem.ram[16] = 16'hFFFF;
		mem.ram[17] = 16'h0002;
		mem.ram[18] = 16'h1234;
		base = mem.wr_top;
		restart();
		finish(base, 16'h1234);
		chk(mem.ram[16], 16'h0000);
		chk(mem.ram[17], 16'h0001);
	endtask

	task automatic t_indirect();
		int base;
		prog({16'h2C10, 16'h487F, 16'h0002});
		mem.ram[16] = 16'h8020;
		mem.ram[32] = 16'h0030;
		mem.ram[48] = 16'h5A5A;
		base = mem.wr_top;
		restart();
		tick(40);
		mr_n = 1'b0;
		tick(6);
		chk({rd_oe, wr_oe, al_oe, bus_oe, grant}, 5'h00);
		mr_n = 1'b1;
		finish(base, 16'h5A5A);
	endtask

	task automatic t_irq();
		int base;
		prog({16'h0004, 16'h0040, 16'h0000, 16'h0000, 16'h607F, 16'h0005});
		mem.ram[64] = 16'h2000;
		mem.ram[65] = 16'h407F;
		mem.ram[66] = 16'h0042;
		base = mem.wr_top;
		srl = 1'b1;
		restart();
		finish(base, 16'h0005);
		srl = 1'b0;
	endtask

	// Add with carries across every nibble, then rotate left through carry
	task automatic t_alu();
		int base;
		prog({16'h2010, 16'h2811, 16'h8E40, 16'h487F, 16'h0004});
		mem.ram[16] = 16'h8FF1;
		mem.ram[17] = 16'h800F;
		base = mem.wr_top;
		restart();
		finish(base, 16'h2001);
	endtask

	// Halt after the first instruction, then continue
	task automatic t_halt();
		int base;
		prog({16'h2010, 16'h407F, 16'h0002});
		mem.ram[16] = 16'h1357;
		base = mem.wr_top;
		halt = 1'b1;
		restart();
		tick(300);
		chk(16'(mem.wr_top - base), 16'h0000);
		halt = 1'b0;
		cont = 1'b1;
		finish(base, 16'h1357);
		cont = 1'b0;
	endtask

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#(60000 * 100);
		mismatches++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end

	initial begin
		rstn = 1'b0;
		mr_n = 1'b1;
		dmr = 1'b0;
		srl = 1'b0;
		hold = 1'b0;
		slow = 1'b0;
		halt = 1'b0;
		cont = 1'b0;
		tick(2);
		rstn = 1'b1;
		t_load();
		t_jump();
		t_skip();
		t_indirect();
		t_irq();
		t_alu();
		t_halt();
		summarize();
	end
endmodule
